/* File: design/sac_ctrl.sv */
/*
  Conversion control of a 13-bit successive approximation converter.
  Assumes chip select and serial clock arrive as pins from a host and the
  comparator output is already on the core clock.
*/
`timescale 1ns/1ns
module sac_ctrl (
  input wire logic core_clk_in,
  input wire logic resetn_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic comp_in,
  input wire logic ctrl_wr_in,
  input wire logic [1:0] mode_in,
  input wire logic ref_sel_in,
  input wire logic coding_in,
  input wire logic [1:0] pd_in,
  input wire logic [1:0] range_in,
  output logic [1:0] mode_out,
  output logic diff_out,
  output logic int_ref_out,
  output logic coding_out,
  output logic [1:0] pd_out,
  output logic [1:0] range_out,
  output logic [21:0] lsb_nv_out,
  output logic power_save_out,
  output logic track_out,
  output logic [sac_pkg::RES_BITS-1:0] dac_code_out,
  output logic dout_out,
  output logic dout_oe_out,
  output logic [sac_pkg::RES_BITS-1:0] result_out,
  output logic result_valid_out
);
  import sac_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] cs_sync_q, cs_sync_d;
  logic [2:0] sclk_sync_q, sclk_sync_d;
  logic cs_lvl_q, cs_lvl_d;
  logic sclk_lvl_q, sclk_lvl_d;
  logic cs_fall, sclk_rise;
  always_comb begin
    cs_sync_d = {cs_sync_q[1:0], cs_n_in};
    sclk_sync_d = {sclk_sync_q[1:0], sclk_in};
    cs_lvl_d = (cs_sync_q[1] == cs_sync_q[2]) ? cs_sync_q[2] : cs_lvl_q;
    sclk_lvl_d = (sclk_sync_q[1] == sclk_sync_q[2]) ? sclk_sync_q[2] : sclk_lvl_q;
    cs_fall = cs_lvl_q && !cs_lvl_d;
    sclk_rise = !sclk_lvl_q && sclk_lvl_d;
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      cs_sync_q <= 3'h7;
      sclk_sync_q <= 3'h7;
      cs_lvl_q <= 1'b1;
      sclk_lvl_q <= 1'b1;
    end else begin
      cs_sync_q <= cs_sync_d;
      sclk_sync_q <= sclk_sync_d;
      cs_lvl_q <= cs_lvl_d;
      sclk_lvl_q <= sclk_lvl_d;
    end
  end

  // ----------------------------------------------------------------
  // Control settings
  // ----------------------------------------------------------------
  logic [1:0] mode_q, mode_d;
  logic ref_q, ref_d;
  logic coding_q, coding_d;
  logic [1:0] pd_q, pd_d;
  logic [1:0] range_q, range_d;

  always_comb begin
    mode_d = mode_q;
    ref_d = ref_q;
    coding_d = coding_q;
    pd_d = pd_q;
    range_d = range_q;
    if (ctrl_wr_in) begin
      mode_d = mode_in;
      ref_d = ref_sel_in;
      coding_d = coding_in;
      pd_d = pd_in;
      range_d = range_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      mode_q <= MODE_SINGLE8;
      ref_q <= REF_EXTERNAL;
      coding_q <= CODING_TWOS;
      pd_q <= PD_NONE;
      range_q <= RANGE_PM10;
    end else begin
      mode_q <= mode_d;
      ref_q <= ref_d;
      coding_q <= coding_d;
      pd_q <= pd_d;
      range_q <= range_d;
    end
  end

  always_comb begin
    mode_out = mode_q;
    diff_out = (mode_q != MODE_SINGLE8);
    int_ref_out = (ref_q == REF_INTERNAL);
    coding_out = coding_q;
    pd_out = pd_q;
    range_out = range_q;
    case (range_q)
      RANGE_PM10: lsb_nv_out = LSB_PM10_NV;
      RANGE_PM5: lsb_nv_out = LSB_PM5_NV;
      RANGE_PM2P5: lsb_nv_out = LSB_PM2P5_NV;
      default: lsb_nv_out = LSB_PM5_NV;
    endcase
  end
  // ----------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------
  sac_state_type state_q, state_d;
  logic [3:0] edge_cnt_q, edge_cnt_d;
  logic [3:0] bit_idx_q, bit_idx_d;
  logic [RES_BITS-1:0] trial_q, trial_d;
  logic [RES_BITS-1:0] result_q, result_d;
  logic frame_coding_q, frame_coding_d;
  logic dout_q, dout_d;
  logic valid_q, valid_d;
  logic [RES_BITS-1:0] kept;

  always_comb begin
    state_d = state_q;
    edge_cnt_d = edge_cnt_q;
    bit_idx_d = bit_idx_q;
    trial_d = trial_q;
    result_d = result_q;
    frame_coding_d = frame_coding_q;
    dout_d = dout_q;
    valid_d = 1'b0;
    kept = trial_q;
    if (!comp_in) begin
      kept[bit_idx_q] = 1'b0;
    end
    case (state_q)
      ST_TRACK: begin
        if (cs_fall) begin
          state_d = ST_CONV;
          edge_cnt_d = 4'h0;
          bit_idx_d = BIT_IDX_MSB;
          trial_d = TRIAL_MSB;
          frame_coding_d = coding_q;
          dout_d = 1'b0;
        end
      end
      ST_CONV: begin
        if (cs_lvl_d) begin
          state_d = ST_TRACK;
        end else if (sclk_rise) begin
          edge_cnt_d = edge_cnt_q + 4'h1;
          trial_d = kept;
          dout_d = kept[bit_idx_q] ^ ((bit_idx_q == BIT_IDX_MSB) && (frame_coding_q == CODING_TWOS));
          if (bit_idx_q == 4'h0) begin
            state_d = ST_DONE;
            valid_d = 1'b1;
            if (frame_coding_q == CODING_TWOS) begin
              result_d = {~kept[RES_BITS-1], kept[RES_BITS-2:0]};
            end else begin
              result_d = kept;
            end
          end else begin
            bit_idx_d = bit_idx_q - 4'h1;
            trial_d[bit_idx_q - 4'h1] = 1'b1;
          end
        end
      end
      ST_DONE: begin
        if (cs_lvl_d) begin
          state_d = ST_TRACK;
        end else if (sclk_rise) begin
          edge_cnt_d = edge_cnt_q + 4'h1;
          if (edge_cnt_q + 4'h1 == EDGE_TRACK) begin
            state_d = ST_TRACK;
          end
        end
      end
      default: state_d = ST_TRACK;
    endcase
  end
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      state_q <= ST_TRACK;
      edge_cnt_q <= 4'h0;
      bit_idx_q <= BIT_IDX_MSB;
      trial_q <= CODE_ZERO;
      result_q <= CODE_ZERO;
      frame_coding_q <= CODING_TWOS;
      dout_q <= 1'b0;
      valid_q <= 1'b0;
    end else begin
      state_q <= state_d;
      edge_cnt_q <= edge_cnt_d;
      bit_idx_q <= bit_idx_d;
      trial_q <= trial_d;
      result_q <= result_d;
      frame_coding_q <= frame_coding_d;
      dout_q <= dout_d;
      valid_q <= valid_d;
    end
  end
  always_comb begin
    track_out = (state_q == ST_TRACK);
    power_save_out = (state_q == ST_TRACK) && cs_lvl_q && (pd_q != PD_NONE);
    dac_code_out = trial_q;
    dout_out = dout_q;
    dout_oe_out = !cs_lvl_q;
    result_out = result_q;
    result_valid_out = valid_q;
  end
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_last_bit;
    (state_q == ST_CONV) && sclk_rise && !cs_lvl_d && (bit_idx_q == 4'h0);
  endsequence
  sequence s_one_pulse;
    result_valid_out ##1 !result_valid_out;
  endsequence
  property p_track_edge;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (state_q == ST_DONE) && sclk_rise && !cs_lvl_d && (edge_cnt_q == EDGE_LAST_BIT) |=> track_out;
  endproperty
  a_track_edge: assert property (p_track_edge) else $error("no tracking on edge 14");
  property p_hold_start;
    @(posedge core_clk_in) disable iff (!resetn_in)
      cs_fall && track_out |=> !track_out && (dac_code_out == TRIAL_MSB);
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("no hold at frame start");
  property p_defaults;
    @(posedge core_clk_in) disable iff (!resetn_in)
      $rose(resetn_in) |-> (mode_out == MODE_SINGLE8) && !int_ref_out && (coding_out == CODING_TWOS);
  endproperty
  a_defaults: assert property (p_defaults) else $error("wrong power-up settings");
  property p_cfg_write;
    @(posedge core_clk_in) disable iff (!resetn_in)
      ctrl_wr_in |=> (mode_out == $past(mode_in)) && (coding_out == $past(coding_in))
        && (int_ref_out == $past(ref_sel_in));
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("settings not written");
  property p_ref_stable;
    @(posedge core_clk_in) disable iff (!resetn_in)
      !ctrl_wr_in |=> $stable(int_ref_out) && $stable(coding_out);
  endproperty
  a_ref_stable: assert property (p_ref_stable) else $error("setting changed without write");
  property p_power_save;
    @(posedge core_clk_in) disable iff (!resetn_in)
      power_save_out |-> track_out && (pd_out != PD_NONE) && !dout_oe_out;
  endproperty
  a_power_save: assert property (p_power_save) else $error("power saving during frame");
  property p_done;
    @(posedge core_clk_in) disable iff (!resetn_in)
      s_last_bit |=> s_one_pulse;
  endproperty
  a_done: assert property (p_done) else $error("completion pulse wrong");
  property p_bit_count;
    @(posedge core_clk_in) disable iff (!resetn_in)
      result_valid_out |-> (edge_cnt_q == EDGE_LAST_BIT);
  endproperty
  a_bit_count: assert property (p_bit_count) else $error("result not after 13 edges");
  property p_coding;
    @(posedge core_clk_in) disable iff (!resetn_in)
      result_valid_out |-> (result_out[RES_BITS-1] != trial_q[RES_BITS-1]) == (frame_coding_q == CODING_TWOS);
  endproperty
  a_coding: assert property (p_coding) else $error("output coding wrong");
  property p_lsb;
    @(posedge core_clk_in) disable iff (!resetn_in)
      (range_out == RANGE_PM10) |-> (lsb_nv_out == LSB_PM10_NV);
  endproperty
  a_lsb: assert property (p_lsb) else $error("wrong LSB weight");
endmodule

/* File: design/sac_pkg.sv */
/*
  Constants for the converter control block: coding, mode, range and
  power-down encodings, reset values, frame counts and LSB weights.
  Assumes a single core clock domain and no bus.
*/
package sac_pkg;
  // ----------------------------------------------------------------
  // Result format
  // ----------------------------------------------------------------
  localparam int RES_BITS = 13;
  localparam int CODE_COUNT = 8192;
  localparam logic [3:0] EDGE_LAST_BIT = 4'hD;
  localparam logic [3:0] EDGE_TRACK = 4'hE;
  localparam logic [3:0] BIT_IDX_MSB = 4'hC;
  localparam logic [RES_BITS-1:0] TRIAL_MSB = 13'h1000;
  localparam logic [RES_BITS-1:0] CODE_ZERO = 13'h0000;
  // ----------------------------------------------------------------
  // Control encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_SINGLE8 = 2'h0;
  localparam logic [1:0] MODE_DIFF4 = 2'h1;
  localparam logic [1:0] MODE_PSEUDO4 = 2'h2;
  localparam logic [1:0] MODE_PSEUDO7 = 2'h3;
  localparam logic CODING_TWOS = 1'b0;
  localparam logic CODING_BINARY = 1'b1;
  localparam logic REF_EXTERNAL = 1'b0;
  localparam logic REF_INTERNAL = 1'b1;
  localparam logic [1:0] PD_NONE = 2'h0;
  localparam logic [1:0] RANGE_PM10 = 2'h0;
  localparam logic [1:0] RANGE_PM5 = 2'h1;
  localparam logic [1:0] RANGE_PM2P5 = 2'h2;
  localparam logic [1:0] RANGE_0TO10 = 2'h3;
  // ----------------------------------------------------------------
  // LSB weights in nanovolts
  // ----------------------------------------------------------------
  localparam logic [21:0] LSB_PM10_NV = 22'h253F28;
  localparam logic [21:0] LSB_PM5_NV = 22'h129DA0;
  localparam logic [21:0] LSB_PM2P5_NV = 22'h094ED0;
  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_TRACK = 3'b001,
    ST_CONV = 3'b010,
    ST_DONE = 3'b100
  } sac_state_type;
endpackage

/* File: test/sac_host.sv */
/*
  Host model: drives chip select and a 320 ns serial clock in frames.
  Assumes the bench calls frame() and owns the 25 MHz core clock.
*/
`timescale 1ns/1ns
module sac_host (
  output logic cs_n_out,
  output logic sclk_out,
  output int edges_out,
  input wire logic core_clk_in
);
  // --------------------------------------------------------------
  // Frame generation
  // --------------------------------------------------------------
  initial begin
    cs_n_out = 1'b1;
    sclk_out = 1'b0;
    edges_out = 0;
  end
  task automatic frame(input int n);
    @(posedge core_clk_in);
    cs_n_out <= 1'b0;
    edges_out <= 0;
    repeat (8) @(posedge core_clk_in);
    for (int i = 1; i <= n; i++) begin
      sclk_out <= 1'b1;
      edges_out <= i;
      repeat (4) @(posedge core_clk_in);
      sclk_out <= 1'b0;
      repeat (4) @(posedge core_clk_in);
    end
    repeat (4) @(posedge core_clk_in);
    cs_n_out <= 1'b1;
    repeat (8) @(posedge core_clk_in);
  endtask
endmodule

/* File: test/sar_adc_conversion_control_bench.sv */
/*
  Self-checking bench for the converter control block.
  Assumes sac_pkg, sac_ctrl and the host model are compiled first.
*/
`timescale 1ns/1ns
module sar_adc_conversion_control_bench;
  import sac_pkg::*;
  logic clk, rst_n, comp, wr, ref_sel, coding, cs_n, sclk;
  logic [1:0] mode, pd, rng, mode_o, pd_o, rng_o;
  logic diff_o, iref_o, cod_o, ps_o, trk_o, dout_o, oe_o, vld_o, trk13, trk14;
  logic [21:0] lsb_o;
  logic [RES_BITS-1:0] dac_o, res_o;
  int edges, n_mismatch, n_checks, target, cycles, m_coding, i, exp_word;
  int exp_q[$];
  int lsb_tab[4] = '{2441000, 1220000, 610000, 1220000};

  sac_host i_host (.cs_n_out(cs_n), .sclk_out(sclk), .edges_out(edges), .core_clk_in(clk));
  sac_ctrl i_dut (.core_clk_in(clk), .resetn_in(rst_n), .cs_n_in(cs_n), .sclk_in(sclk), .comp_in(comp),
    .ctrl_wr_in(wr), .mode_in(mode), .ref_sel_in(ref_sel), .coding_in(coding), .pd_in(pd),
    .range_in(rng), .mode_out(mode_o), .diff_out(diff_o), .int_ref_out(iref_o), .coding_out(cod_o),
    .pd_out(pd_o), .range_out(rng_o), .lsb_nv_out(lsb_o), .power_save_out(ps_o), .track_out(trk_o),
    .dac_code_out(dac_o), .dout_out(dout_o), .dout_oe_out(oe_o), .result_out(res_o),
    .result_valid_out(vld_o));

  // --------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------
  task automatic check(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic ctrl(input logic [1:0] m, input logic r, input logic c, input logic [1:0] p,
    input logic [1:0] g);
    @(posedge clk);
    mode <= m;
    ref_sel <= r;
    coding <= c;
    pd <= p;
    rng <= g;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    m_coding = int'(c);
    @(posedge clk);
  endtask
  task automatic conv(input int t, input int n);
    target = t;
    exp_word = (m_coding != 0) ? t : (t ^ 4096);
    if (n >= 13) begin
      exp_q.push_back(exp_word);
    end
    i_host.frame(n);
  endtask

  // --------------------------------------------------------------
  // Comparator, result model, timeout
  // --------------------------------------------------------------
  always @(posedge clk) begin
    comp <= (dac_o <= 13'(target));
    if (!cs_n && edges == 13) trk13 <= trk_o;
    if (!cs_n && edges == 14) trk14 <= trk_o;
    if (!cs_n && !sclk && edges inside {[1:13]}) check(dout_o === exp_word[13 - edges], "serial bit");
    if (vld_o === 1'b1) begin
      if (exp_q.size() == 0) check(1'b0, "result without frame");
      else check(res_o === 13'(exp_q.pop_front()), "result code");
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    {rst_n, comp, wr, ref_sel, coding, mode, pd, rng} = '0;
    {n_mismatch, n_checks, target, cycles, m_coding, exp_word} = '0;
    void'($urandom(60));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    check(mode_o === MODE_SINGLE8 && diff_o === 1'b0, "mode reset");
    check(iref_o === REF_EXTERNAL, "ref reset");
    check(cod_o === CODING_TWOS, "coding reset");
    check(trk_o === 1'b1 && oe_o === 1'b0, "idle reset");
    conv(0, 14);
    conv(8191, 14);
    for (i = 0; i < 4; i++) begin
      ctrl(i[1:0], i[0], CODING_TWOS, PD_NONE, i[1:0]);
      check(mode_o === i[1:0] && diff_o === (i != 0), "mode");
      check(iref_o === i[0], "reference");
      check(lsb_o === 22'(lsb_tab[i]) && rng_o === i[1:0], "lsb weight");
      conv($urandom_range(8191), 14);
    end
    ctrl(MODE_SINGLE8, REF_EXTERNAL, CODING_BINARY, PD_NONE, RANGE_PM10);
    check(cod_o === CODING_BINARY, "coding set");
    for (i = 0; i < 4; i++) conv($urandom_range(8191), 14);
    conv(0, 14);
    conv(8191, 14);
    fork
      conv($urandom_range(8191), 14);
      begin
        repeat (40) @(posedge clk);
        ctrl(MODE_SINGLE8, REF_EXTERNAL, CODING_TWOS, 2'h1, RANGE_PM10);
      end
    join
    check(trk13 === 1'b0 && trk14 === 1'b1, "track edge");
    check(ps_o === 1'b1 && oe_o === 1'b0 && pd_o === 2'h1, "power save");
    conv($urandom_range(8191), 14);
    conv($urandom_range(8191), 5);
    check(trk_o === 1'b1 && exp_q.size() == 0, "abort");
    ctrl(MODE_SINGLE8, REF_EXTERNAL, CODING_TWOS, PD_NONE, RANGE_PM10);
    check(ps_o === 1'b0, "no power save");
    print_verdict();
  end
endmodule
